// ---- tb/spau_decoder_model.sv ----
// Purpose: behavioural decoder with random or held operand values feeding the unit
// Assumes: requests and stalls change 1 ns after the rising edge
// Notes:   idle fields keep changing, operand values only while use_hold is low
`timescale 1ns/10ps
`default_nettype none
module spau_decoder_model (
    input  wire logic            clk,
    input  wire logic            reset_n,
    input  wire logic            run,
    input  wire logic            stall,
    input  wire logic            bad_ok,
    input  wire logic            use_hold,
    input  wire logic [31:0]     hold_a,
    input  wire logic [31:0]     hold_b,
    output logic                 ce,
    output logic                 req_valid,
    output spau_pkg::spau_req_type req
);
    integer seed;
    spau_pkg::spau_req_type r;

    initial begin
        seed = 33;
        ce = 1'h1;
        req_valid = 1'h0;
        req = '0;
    end

    always @(posedge clk) begin
        #1;
        req_valid = run && reset_n && (($random(seed) & 3) != 0);
        ce = !stall || (($random(seed) & 3) != 0);
        r.op = spau_pkg::spau_op_type'(($random(seed) & 32'h7fff) % 12);
        r.dest_given = 1'($random(seed));
        r.dest_idx = 4'($random(seed));
        r.first_idx = 4'($random(seed));
        // keep off stack pointer and counter
        if (!bad_ok && r.dest_idx inside {spau_pkg::SP_IDX, spau_pkg::PC_IDX})
            r.dest_idx = 4'h0;
        if (!bad_ok && r.first_idx inside {spau_pkg::SP_IDX, spau_pkg::PC_IDX})
            r.first_idx = 4'h1;
        r.first_val = use_hold ? hold_a : $random(seed);
        r.second_val = use_hold ? hold_b : $random(seed);
        req = r;
    end
endmodule
`default_nettype wire

// ---- tb/spau_top_bench.sv ----
// Purpose: self-checking bench for the packed add/subtract unit
// Assumes: one-cycle writeback, CE low freezes all state
// Notes:   prediction made at falling edge, checked one cycle later
`timescale 1ns/10ps
`default_nettype none
module spau_top_bench;
    logic CLK, RESET_N, CE, REQ_VALID, REQ_READY, BAD_REG;
    logic run, stall, bad_ok, use_hold, exp_bad;
    logic [31:0] hold_a, hold_b;
    spau_pkg::spau_req_type REQ;
    spau_pkg::spau_wb_type WB, exp_wb;
    int n_fail, checked;
    logic [31:0] cv [4] = '{32'h8080_8000, 32'h7f7f_7fff,
                            32'hffff_ffff, 32'h0000_0001};

    spau_top spau_top_inst (.CLK(CLK), .RESET_N(RESET_N), .CE(CE),
        .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY),
        .WB(WB), .BAD_REG(BAD_REG));
    spau_decoder_model spau_decoder_model_inst (.clk(CLK),
        .reset_n(RESET_N), .run(run), .stall(stall), .bad_ok(bad_ok),
        .use_hold(use_hold), .hold_a(hold_a), .hold_b(hold_b), .ce(CE),
        .req_valid(REQ_VALID), .req(REQ));

    function automatic logic [15:0] ln(input logic [15:0] a, b,
                                       input logic s, h, bw);
        logic signed [16:0] x, y, r;
        x = bw ? {{9{a[7]}}, a[7:0]} : {a[15], a};
        y = bw ? {{9{b[7]}}, b[7:0]} : {b[15], b};
        r = s ? x - y : x + y;
        return h ? r[16:1] : r[15:0];
    endfunction

    // Codes follow the package enum order
    function automatic logic [31:0] calc(input spau_pkg::spau_req_type q);
        logic [31:0] a, b, r;
        logic [15:0] t;
        logic s, h;
        int o;
        a = q.first_val;
        b = q.second_val;
        o = int'(q.op);
        h = o inside {2, 3, 4, 5, 6, 7};
        s = o inside {6, 7, 8, 9};
        if (o inside {1, 3, 7, 9}) begin
            for (int i = 0; i < 4; i++) begin
                t = ln({8'h0, a[8*i+:8]}, {8'h0, b[8*i+:8]}, s, h, 1'h1);
                r[8*i+:8] = t[7:0];
            end
        end else if (o inside {4, 10}) begin
            r = {ln(a[31:16], b[15:0], 1'h0, h, 1'h0),
                 ln(a[15:0], b[31:16], 1'h1, h, 1'h0)};
        end else if (o inside {5, 11}) begin
            r = {ln(a[31:16], b[15:0], 1'h1, h, 1'h0),
                 ln(a[15:0], b[31:16], 1'h0, h, 1'h0)};
        end else begin
            r = {ln(a[31:16], b[31:16], s, h, 1'h0),
                 ln(a[15:0], b[15:0], s, h, 1'h0)};
        end
        return r;
    endfunction

    task automatic chk(input logic [31:0] seen, exp, input string m);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s %h %h", $time, m, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_fail, checked);
        if (n_fail == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(negedge CLK) begin
        if (!RESET_N) begin
            exp_wb = '0;
            exp_bad = 1'h0;
        end
        chk(WB.value[7:0], exp_wb.value[7:0], "b0");
        chk(WB.value[15:8], exp_wb.value[15:8], "b1");
        chk(WB.value[23:16], exp_wb.value[23:16], "b2");
        chk(WB.value[31:24], exp_wb.value[31:24], "b3");
        chk(WB.dest_idx, exp_wb.dest_idx, "dest");
        chk(WB.valid, exp_wb.valid, "valid");
        chk(REQ_READY, 1'h1, "ready");
        chk(BAD_REG, exp_bad, "bad reg");
        if (CE) begin
            exp_wb.valid = REQ_VALID;
            if (REQ_VALID) begin
                exp_wb.value = calc(REQ);
                exp_wb.dest_idx = REQ.dest_given ? REQ.dest_idx
                                                 : REQ.first_idx;
                exp_bad = REQ.first_idx inside {4'hd, 4'hf} ||
                    (REQ.dest_given && REQ.dest_idx inside {4'hd, 4'hf});
            end
        end
    end

    initial begin
        CLK = 1'h0;
        forever #2 CLK = ~CLK;
    end

    // Long enough for all phases with margin
    initial begin
        repeat (20000) @(posedge CLK);
        n_fail++;
        report_and_stop;
    end

    initial begin
        {RESET_N, run, stall, bad_ok, use_hold} = 5'h0;
        {hold_a, hold_b} = 64'h0;
        {n_fail, checked} = 64'h0;
        repeat (20) @(posedge CLK);
        #1 RESET_N = 1'h1;
        run = 1'h1;
        repeat (2000) @(posedge CLK);
        #1 stall = 1'h1;
        repeat (500) @(posedge CLK);
        #1 stall = 1'h0;
        use_hold = 1'h1;
        foreach (cv[i]) begin
            foreach (cv[j]) begin
                hold_a = cv[i];
                hold_b = cv[j];
                repeat (20) @(posedge CLK);
                #1;
            end
        end
        use_hold = 1'h0;
        bad_ok = 1'h1;
        repeat (200) @(posedge CLK);
        // Reset two cycles after requests stop clears writeback
        #1 run = 1'h0;
        repeat (2) @(posedge CLK);
        #1 RESET_N = 1'h0;
        repeat (3) @(posedge CLK);
        #1 RESET_N = 1'h1;
        run = 1'h1;
        repeat (200) @(posedge CLK);
        report_and_stop;
    end
endmodule
`default_nettype wire

// ---- verilog/spau_lane.sv ----
// Purpose: one signed lane adder/subtractor with optional halving
// Assumes: operands are two's complement of width W
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
module spau_lane #(
    parameter int unsigned W = 8
) (
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    input  wire logic         sub,
    input  wire logic         halve,
    output logic      [W-1:0] y
);
    logic [W:0] ext_sum;

    always_comb begin
        if (sub) begin
            ext_sum = {a[W-1], a} - {b[W-1], b};
        end else begin
            ext_sum = {a[W-1], a} + {b[W-1], b};
        end
        if (halve) begin
            y = ext_sum[W:1];
        end else begin
            y = ext_sum[W-1:0];
        end
    end
endmodule
`default_nettype wire

// ---- verilog/spau_pkg.sv ----
// Purpose: shared types and constants for the packed add/subtract unit
// Assumes: 32-bit operands, two halfword or four byte lanes
// Notes:   operation codes are internal to the pipeline
package spau_pkg;

    localparam int unsigned DATA_W    = 32;
    localparam int unsigned HALF_W    = 16;
    localparam int unsigned BYTE_W    = 8;
    localparam int unsigned REG_IDX_W = 4;
    localparam logic [3:0]  SP_IDX    = 4'hd;
    localparam logic [3:0]  PC_IDX    = 4'hf;
    localparam logic [31:0] RESULT_RST = 32'h0;

    typedef enum logic [3:0] {
        SIGNED_LANE_ADD_HALF,
        SIGNED_LANE_ADD_BYTE,
        SIGNED_HALVING_ADD_HALF,
        SIGNED_HALVING_ADD_BYTE,
        SIGNED_HALVING_ADD_SUB_EXCHANGE,
        SIGNED_HALVING_SUB_ADD_EXCHANGE,
        SIGNED_HALVING_SUB_HALF,
        SIGNED_HALVING_SUB_BYTE,
        SIGNED_LANE_SUB_HALF,
        SIGNED_LANE_SUB_BYTE,
        SIGNED_ADD_SUB_EXCHANGE,
        SIGNED_SUB_ADD_EXCHANGE
    } spau_op_type;

    typedef struct packed {
        spau_op_type          op;
        logic                 dest_given;
        logic [3:0]           dest_idx;
        logic [3:0]           first_idx;
        logic [31:0]          first_val;
        logic [31:0]          second_val;
    } spau_req_type;

    typedef struct packed {
        logic                 valid;
        logic [3:0]           dest_idx;
        logic [31:0]          value;
    } spau_wb_type;

endpackage

// ---- verilog/spau_top.sv ----
// Purpose: packed signed add/subtract datapath with one-cycle writeback
// Assumes: decoder keeps stack pointer and program counter out of operands
// Notes:   no condition flag outputs exist, so condition flags cannot change
`timescale 1ns/10ps
`default_nettype none
module spau_top (
    input  wire logic                  CLK,
    input  wire logic                  RESET_N,
    input  wire logic                  CE,
    input  wire logic                  REQ_VALID,
    input  wire spau_pkg::spau_req_type REQ,
    output logic                       REQ_READY,
    output spau_pkg::spau_wb_type      WB,
    output logic                       BAD_REG
);
    logic [3:0]  sub_l;
    logic [3:0]  sub_h;
    logic        halve;
    logic        half_mode;
    logic        xchg;
    logic [31:0] a_h;
    logic [31:0] b_h;
    logic [31:0] y_b;
    logic [31:0] y_h;
    logic [31:0] result_nxt;
    logic [31:0] result_r;
    logic [3:0]  dest_nxt;
    logic [3:0]  dest_r;
    logic        valid_r;
    logic        bad_nxt;
    logic        bad_r;

    assign REQ_READY = 1'b1;

    // Decode lane controls
    always_comb begin
        sub_l     = 4'h0;
        sub_h     = 4'h0;
        halve     = 1'b0;
        half_mode = 1'b1;
        xchg      = 1'b0;
        case (REQ.op)
            spau_pkg::SIGNED_LANE_ADD_HALF: begin
            end
            spau_pkg::SIGNED_LANE_ADD_BYTE: begin
                half_mode = 1'b0;
            end
            spau_pkg::SIGNED_HALVING_ADD_HALF: begin
                halve = 1'b1;
            end
            spau_pkg::SIGNED_HALVING_ADD_BYTE: begin
                halve     = 1'b1;
                half_mode = 1'b0;
            end
            spau_pkg::SIGNED_HALVING_ADD_SUB_EXCHANGE: begin
                halve = 1'b1;
                xchg  = 1'b1;
                sub_h = 4'h1;
            end
            spau_pkg::SIGNED_HALVING_SUB_ADD_EXCHANGE: begin
                halve = 1'b1;
                xchg  = 1'b1;
                sub_h = 4'h2;
            end
            spau_pkg::SIGNED_HALVING_SUB_HALF: begin
                halve = 1'b1;
                sub_h = 4'h3;
            end
            spau_pkg::SIGNED_HALVING_SUB_BYTE: begin
                halve     = 1'b1;
                half_mode = 1'b0;
                sub_l     = 4'hf;
            end
            spau_pkg::SIGNED_LANE_SUB_HALF: begin
                sub_h = 4'h3;
            end
            spau_pkg::SIGNED_LANE_SUB_BYTE: begin
                half_mode = 1'b0;
                sub_l     = 4'hf;
            end
            spau_pkg::SIGNED_ADD_SUB_EXCHANGE: begin
                xchg  = 1'b1;
                sub_h = 4'h1;
            end
            spau_pkg::SIGNED_SUB_ADD_EXCHANGE: begin
                xchg  = 1'b1;
                sub_h = 4'h2;
            end
            default: begin
            end
        endcase
    end

    assign a_h = REQ.first_val;
    assign b_h = xchg ? {REQ.second_val[15:0], REQ.second_val[31:16]}
                      : REQ.second_val;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_byte
            spau_lane #(.W(spau_pkg::BYTE_W)) u_lane (
                .a     (REQ.first_val[gi*8 +: 8]),
                .b     (REQ.second_val[gi*8 +: 8]),
                .sub   (sub_l[gi]),
                .halve (halve),
                .y     (y_b[gi*8 +: 8])
            );
        end
        for (gi = 0; gi < 2; gi++) begin : g_half
            spau_lane #(.W(spau_pkg::HALF_W)) u_lane (
                .a     (a_h[gi*16 +: 16]),
                .b     (b_h[gi*16 +: 16]),
                .sub   (sub_h[gi]),
                .halve (halve),
                .y     (y_h[gi*16 +: 16])
            );
        end
    endgenerate

    assign result_nxt = half_mode ? y_h : y_b;
    assign dest_nxt = REQ.dest_given ? REQ.dest_idx : REQ.first_idx;
    // flag illegal register use, result still written
    assign bad_nxt = (REQ.first_idx == spau_pkg::SP_IDX)
                   | (REQ.first_idx == spau_pkg::PC_IDX)
                   | (REQ.dest_given & ((REQ.dest_idx == spau_pkg::SP_IDX)
                   | (REQ.dest_idx == spau_pkg::PC_IDX)));

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            result_r <= spau_pkg::RESULT_RST;
            dest_r   <= 4'h0;
            bad_r    <= 1'b0;
        end else if (CE && REQ_VALID) begin
            result_r <= result_nxt;
            dest_r   <= dest_nxt;
            bad_r    <= bad_nxt;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            valid_r <= 1'b0;
        end else if (CE) begin
            valid_r <= REQ_VALID;
        end
    end

    // no flag state exists
    // One driver for the whole carrier, not one per field
    assign WB      = '{valid: valid_r, dest_idx: dest_r, value: result_r};
    assign BAD_REG = bad_r;

    property p_dest;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && REQ_VALID && !REQ.dest_given) |=> (WB.dest_idx ==
            $past(REQ.first_idx));
    endproperty
    a_dest: assert property (p_dest) else $error("dest default wrong");

    property p_valid;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && REQ_VALID) |=> WB.valid;
    endproperty
    a_valid: assert property (p_valid) else $error("wb valid missing");

    property p_add16;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && REQ_VALID && REQ.op == spau_pkg::SIGNED_LANE_ADD_HALF)
        |=> WB.value[15:0] == 16'($past(REQ.first_val[15:0])
                                 + $past(REQ.second_val[15:0]));
    endproperty
    a_add16: assert property (p_add16) else $error("add16 wrong");

    property p_sub8;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && REQ_VALID && REQ.op == spau_pkg::SIGNED_LANE_SUB_BYTE)
        |=> WB.value[31:24] == 8'($past(REQ.first_val[31:24])
                                 - $past(REQ.second_val[31:24]));
    endproperty
    a_sub8: assert property (p_sub8) else $error("sub8 wrong");

    property p_hadd16;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && REQ_VALID && REQ.op == spau_pkg::SIGNED_HALVING_ADD_HALF)
        |=> WB.value[31:16] == 16'(17'({$past(REQ.first_val[31]),
            $past(REQ.first_val[31:16])} + {$past(REQ.second_val[31]),
            $past(REQ.second_val[31:16])}) >> 1);
    endproperty
    a_hadd16: assert property (p_hadd16) else $error("hadd16 wrong");

    property p_asx_hi;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && REQ_VALID && REQ.op == spau_pkg::SIGNED_ADD_SUB_EXCHANGE)
        |=> WB.value[31:16] == 16'($past(REQ.first_val[31:16])
                                  + $past(REQ.second_val[15:0]));
    endproperty
    a_asx_hi: assert property (p_asx_hi) else $error("asx high wrong");

    property p_asx_lo;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && REQ_VALID && REQ.op == spau_pkg::SIGNED_ADD_SUB_EXCHANGE)
        |=> WB.value[15:0] == 16'($past(REQ.first_val[15:0])
                                 - $past(REQ.second_val[31:16]));
    endproperty
    a_asx_lo: assert property (p_asx_lo) else $error("asx low wrong");

    property p_sax_hi;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && REQ_VALID && REQ.op == spau_pkg::SIGNED_SUB_ADD_EXCHANGE)
        |=> WB.value[31:16] == 16'($past(REQ.first_val[31:16])
                                  - $past(REQ.second_val[15:0]));
    endproperty
    a_sax_hi: assert property (p_sax_hi) else $error("sax high wrong");

    property p_hold;
        @(posedge CLK) disable iff (!RESET_N)
        !CE |=> $stable(WB.value) && $stable(WB.valid);
    endproperty
    a_hold: assert property (p_hold) else $error("freeze broken");
endmodule
`default_nettype wire
